/* File: rtl/bgc_top.sv */
// commutation gate control with ahb-lite register slave
//
// Behaviour
// - motor bit off gives plain pwm outputs
// - gating works only in complementary/reset-sync modes
// - reverse bit picks level or pwm output
// - positive bit picks level or pwm output
// - feedback bit 0 uses hall capture signals
// - feedback bit 1 uses software phase bits
// - software phase bits replace capture inputs
// - phase code decodes to on pin pairs
// - gate register bit 7 reads one
// - read-only 16-bit subcounter, resets to zero
// - restart loads dead-time offset into counter three
// - dead-time offset 16 bits, resets all ones
// - pin drives only when master enable set
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module bgc_top (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic core_ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [5:0] pwm_wave,
    input wire logic [2:0] hall_capture,
    input wire logic pos_level_high,
    input wire logic rev_level_high,
    output logic [5:0] phase_out,
    output logic [5:0] phase_oe,
    output logic [15:0] counter_three
);
    // register storage
    logic [7:0] motor_gate_control;
    logic [15:0] complementary_subcounter;
    logic [15:0] dead_time_offset;
    logic [5:0] output_master_enable;
    logic [2:0] timer_control; // run bit and mode
    logic run_prev; // running flag one cycle ago
    // bus data phase bookkeeping
    logic wr_pend; // a write waits for its data
    logic [7:0] wr_addr; // offset of that write
    // next values
    logic [7:0] next_motor_gate_control;
    logic [15:0] next_complementary_subcounter;
    logic [15:0] next_dead_time_offset;
    logic [5:0] next_output_master_enable;
    logic [2:0] next_timer_control;
    logic next_run_prev;
    logic next_wr_pend;
    logic [7:0] next_wr_addr;
    logic [31:0] next_hrdata;
    logic [15:0] next_counter_three;
    logic [5:0] next_phase_out;
    logic [5:0] next_phase_oe;
    // decode helpers
    logic addr_take; // valid address phase to this slave
    logic wr_ok; // data phase write, halfword or wider
    logic mode_active; // commutation gating in force
    logic restart; // counter three loaded with offset, subcounter cleared
    logic running; // counting in complementary mode
    bgc_pkg::bgc_mode_e mode;
    bgc_if pif ();

    bgc_decode u_dec (
        .pif(pif)
    );

    // address phase qualifier and data phase write strobe
    always_comb begin
        addr_take = hsel && hready && htrans[bgc_pkg::HTRANS_ACT];
        // size was judged in the address phase, see wr_pend
        wr_ok = wr_pend;
    end

    // mode decode and commutation source selection
    always_comb begin
        mode = bgc_bits_to_mode(timer_control[1:0]);
        mode_active = motor_gate_control[bgc_pkg::GATE_MOTOR]
            && (mode == bgc_pkg::BGC_COMP
            || mode == bgc_pkg::BGC_RSYNC);
        if (motor_gate_control[bgc_pkg::GATE_SRC]) begin
            pif.code = motor_gate_control[2:0];
        end else begin
            pif.code = hall_capture;
        end
        running = timer_control[bgc_pkg::CTL_RUN]
            && (mode == bgc_pkg::BGC_COMP);
        restart = running && !run_prev;
    end

    // unknown mode codes fall back to normal
    function automatic bgc_pkg::bgc_mode_e bgc_bits_to_mode(
        input logic [1:0] b
    );
        bgc_pkg::bgc_mode_e m;
        m = bgc_pkg::BGC_NORMAL;
        if (b == bgc_pkg::BGC_COMP) begin
            m = bgc_pkg::BGC_COMP;
        end else if (b == bgc_pkg::BGC_RSYNC) begin
            m = bgc_pkg::BGC_RSYNC;
        end
        return m;
    endfunction : bgc_bits_to_mode

    // bus slave next state: latch writes, prepare read data
    always_comb begin
        // byte writes dropped while hsize still belongs to them
        next_wr_pend = addr_take && hwrite
            && (hsize >= bgc_pkg::SIZE_HALF);
        next_wr_addr = addr_take ? haddr[7:0] : wr_addr;
        next_motor_gate_control = motor_gate_control;
        next_dead_time_offset = dead_time_offset;
        next_output_master_enable = output_master_enable;
        next_timer_control = timer_control;
        next_hrdata = '0;
        // write commits in its data phase
        if (wr_ok) begin
            unique case (wr_addr)
                bgc_pkg::ADDR_GATE: begin
                    // reserved bit held at one
                    next_motor_gate_control = hwdata[7:0]
                        | bgc_pkg::GATE_RSV;
                end
                bgc_pkg::ADDR_DTO: begin
                    next_dead_time_offset = hwdata[15:0];
                end
                bgc_pkg::ADDR_OME: begin
                    next_output_master_enable = hwdata[5:0];
                end
                bgc_pkg::ADDR_CTL: begin
                    next_timer_control = hwdata[2:0];
                end
                // subcounter and unmapped offsets ignore writes
                default: begin
                end
            endcase
        end
        // read data registered for the data phase
        if (addr_take && !hwrite) begin
            unique case (haddr[7:0])
                bgc_pkg::ADDR_GATE: begin
                    next_hrdata[7:0] = motor_gate_control
                        | bgc_pkg::GATE_RSV;
                end
                bgc_pkg::ADDR_SUB: begin
                    next_hrdata[15:0] = complementary_subcounter;
                end
                bgc_pkg::ADDR_DTO: begin
                    next_hrdata[15:0] = dead_time_offset;
                end
                bgc_pkg::ADDR_OME: begin
                    next_hrdata[7:0] = bgc_pkg::OME_RSV
                        | {2'h0, output_master_enable};
                end
                bgc_pkg::ADDR_CTL: begin
                    next_hrdata[2:0] = timer_control;
                end
                // unmapped offsets read zero
                default: begin
                end
            endcase
        end
    end

    // counters: restart loads offset, then both count up
    always_comb begin
        next_run_prev = running;
        next_counter_three = counter_three;
        next_complementary_subcounter = complementary_subcounter;
        if (restart) begin
            next_counter_three = dead_time_offset;
            next_complementary_subcounter = bgc_pkg::SUB_RST;
        end else if (running) begin
            next_counter_three = 16'(counter_three + bgc_pkg::CNT_STEP);
            next_complementary_subcounter =
                16'(complementary_subcounter + bgc_pkg::CNT_STEP);
        end
    end

    // pin levels: ordinary pwm, or gated on/off per phase code
    always_comb begin
        logic sel;
        logic act;
        sel = 1'b0;
        act = 1'b0;
        for (int i = 0; i < bgc_pkg::NPIN; i++) begin
            if (i < bgc_pkg::NPOS) begin
                sel = motor_gate_control[bgc_pkg::GATE_P];
                act = pos_level_high;
            end else begin
                sel = motor_gate_control[bgc_pkg::GATE_N];
                act = rev_level_high;
            end
            if (!mode_active) begin
                next_phase_out[i] = pwm_wave[i];
            end else if (!pif.on[i]) begin
                next_phase_out[i] = !act;
            end else if (sel) begin
                next_phase_out[i] = pwm_wave[i];
            end else begin
                next_phase_out[i] = act;
            end
        end
        next_phase_oe = output_master_enable;
    end

    // all state registers, frozen while the clock enable is low
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            motor_gate_control <= bgc_pkg::GATE_RST;
            complementary_subcounter <= bgc_pkg::SUB_RST;
            dead_time_offset <= bgc_pkg::DTO_RST;
            output_master_enable <= bgc_pkg::OME_RST;
            timer_control <= bgc_pkg::CTL_RST;
            run_prev <= 1'b0;
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata <= '0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            counter_three <= '0;
            phase_out <= '0;
            phase_oe <= '0;
        end else if (core_ce) begin
            motor_gate_control <= next_motor_gate_control;
            complementary_subcounter <= next_complementary_subcounter;
            dead_time_offset <= next_dead_time_offset;
            output_master_enable <= next_output_master_enable;
            timer_control <= next_timer_control;
            run_prev <= next_run_prev;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            counter_three <= next_counter_three;
            phase_out <= next_phase_out;
            phase_oe <= next_phase_oe;
        end
    end

    // checks on the block's own behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic rd_gate; // data phase of a gate register read
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_gate <= 1'b0;
        end else if (core_ce) begin
            rd_gate <= addr_take && !hwrite
                && haddr[7:0] == bgc_pkg::ADDR_GATE;
        end
    end

    property p_rsv_read;
        rd_gate |-> hrdata[7];
    endproperty
    a_rsv_read: assert property (p_rsv_read)
        else $error("gate reserved bit read as zero");

    property p_plain_pwm;
        core_ce && !mode_active |=> phase_out == $past(pwm_wave);
    endproperty
    a_plain_pwm: assert property (p_plain_pwm)
        else $error("pins not plain pwm while gating off");

    property p_normal_mode;
        core_ce && mode == bgc_pkg::BGC_NORMAL
            |-> !mode_active;
    endproperty
    a_normal_mode: assert property (p_normal_mode)
        else $error("gating active outside pwm modes");

    property p_rev_level;
        core_ce && mode_active && pif.on[3]
            && !motor_gate_control[bgc_pkg::GATE_N]
            |=> phase_out[3] == $past(rev_level_high);
    endproperty
    a_rev_level: assert property (p_rev_level)
        else $error("reverse pin not at level");

    property p_pos_pwm;
        core_ce && mode_active && pif.on[0]
            && motor_gate_control[bgc_pkg::GATE_P]
            |=> phase_out[0] == $past(pwm_wave[0]);
    endproperty
    a_pos_pwm: assert property (p_pos_pwm)
        else $error("positive pin not pwm");

    property p_hall_src;
        !motor_gate_control[bgc_pkg::GATE_SRC]
            |-> pif.code == hall_capture;
    endproperty
    a_hall_src: assert property (p_hall_src)
        else $error("code not from hall inputs");

    property p_soft_src;
        motor_gate_control[bgc_pkg::GATE_SRC]
            |-> pif.code == motor_gate_control[2:0];
    endproperty
    a_soft_src: assert property (p_soft_src)
        else $error("code not from software bits");

    property p_decode;
        (pif.code == 3'h1 |-> pif.on == 6'h21)
            and (pif.code == 3'h7 |-> pif.on == 6'h00);
    endproperty
    a_decode: assert property (p_decode)
        else $error("phase decode wrong");

    property p_restart;
        core_ce && restart |=> counter_three == $past(dead_time_offset)
            && complementary_subcounter == bgc_pkg::SUB_RST;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart did not load offset");

    property p_sub_ro;
        core_ce && wr_pend && wr_addr == bgc_pkg::ADDR_SUB && !running
            |=> $stable(complementary_subcounter);
    endproperty
    a_sub_ro: assert property (p_sub_ro)
        else $error("subcounter changed by write");

    property p_master_en;
        core_ce |=> phase_oe == $past(output_master_enable);
    endproperty
    a_master_en: assert property (p_master_en)
        else $error("pin enable not following register");

    property p_off_level;
        core_ce && mode_active && !pif.on[5]
            |=> phase_out[5] == !$past(rev_level_high);
    endproperty
    a_off_level: assert property (p_off_level)
        else $error("gated-off pin not inactive");

    c_restart: cover property (core_ce && restart);
    c_hall_on: cover property (mode_active && pif.on != 6'h00);
    c_soft: cover property (mode_active
        && motor_gate_control[bgc_pkg::GATE_SRC]);
endmodule : bgc_top

/* File: rtl/bgc_pkg.sv */
// constants and types shared by the commutation gate control block
package bgc_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] ADDR_GATE = 8'h00;
    localparam logic [7:0] ADDR_SUB = 8'h04;
    localparam logic [7:0] ADDR_DTO = 8'h08;
    localparam logic [7:0] ADDR_OME = 8'h0c;
    localparam logic [7:0] ADDR_CTL = 8'h10;
    // reset values, fixed read bits and counter step
    localparam logic [7:0] GATE_RST = 8'h80;
    localparam logic [7:0] GATE_RSV = 8'h80;
    localparam logic [15:0] SUB_RST = 16'h0000;
    localparam logic [15:0] DTO_RST = 16'hffff;
    localparam logic [5:0] OME_RST = 6'h00;
    localparam logic [7:0] OME_RSV = 8'hc0;
    localparam logic [2:0] CTL_RST = 3'h0;
    localparam logic [15:0] CNT_STEP = 16'h0001;
    // gate and timer control field positions
    localparam int GATE_MOTOR = 6;
    localparam int GATE_N = 5;
    localparam int GATE_P = 4;
    localparam int GATE_SRC = 3;
    localparam int CTL_RUN = 2;
    // bus encodings
    localparam logic [2:0] SIZE_HALF = 3'h1;
    localparam int HTRANS_ACT = 1;
    // pin order: u+, v+, w+, u-, v-, w-
    localparam int NPIN = 6;
    localparam int NPOS = 3;
    // timer operating mode
    typedef enum logic [1:0] {
        BGC_NORMAL = 2'h0,
        BGC_COMP = 2'h1,
        BGC_RSYNC = 2'h2
    } bgc_mode_e;
    // phase code (w,v,u) to pins that are on
    localparam logic [5:0] PHASE_ON [8] = '{
        6'h00, 6'h21, 6'h0a, 6'h22, 6'h14, 6'h11, 6'h0c, 6'h00
    };
endpackage : bgc_pkg

/* File: rtl/bgc_if.sv */
// phase code and on-pin vector between the top and the decoder
`timescale 1ns/1ps
interface bgc_if;
    logic [2:0] code; // selected phase code (w,v,u)
    logic [5:0] on; // pins that the code turns on
    modport src (output code, input on);
    modport dec (input code, output on);
endinterface : bgc_if

/* File: rtl/bgc_decode.sv */
// decoder from commutation phase code to the six pin on-states
`timescale 1ns/1ps
module bgc_decode (
    bgc_if.dec pif
);
    // table lookup, codes 0 and 7 turn every pin off
    always_comb begin
        pif.on = bgc_pkg::PHASE_ON[pif.code];
    end
endmodule : bgc_decode

/* File: tb/bgc_hall_model.sv */
// hall sensor model: turns a rotor step into the three capture levels
`timescale 1ns/1ps
module bgc_hall_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [2:0] step,
    output logic [2:0] hall_capture
);
    // sensor pattern {w,v,u} for the six rotor sectors, 120 degree spacing
    localparam logic [2:0] SECTOR [6] = '{
        3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4
    };

    // sensors settle one clock after the rotor moves into a new sector
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hall_capture <= 3'h0;
        end else if (step < 3'h6) begin
            hall_capture <= SECTOR[step];
        end
    end
endmodule : bgc_hall_model

/* File: tb/tb_bgc_top.sv */
// self-checking bench for the commutation gate control block
`timescale 1ns/1ps
module tb_bgc_top;
    logic core_clk, nrst, core_ce, hsel, hwrite, pos_hi, rev_hi;
    logic [31:0] haddr, hwdata, hrdata, rd, rd2;
    logic [1:0] htrans;
    logic [2:0] hsize, hall, step;
    logic hready, hresp;
    logic [5:0] pwm, phase_out, phase_oe;
    logic [15:0] cnt3;
    int err_count, checks, cycles;

    bgc_top u_bgc_top (.core_clk(core_clk), .nrst(nrst), .core_ce(core_ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .pwm_wave(pwm),
        .hall_capture(hall), .pos_level_high(pos_hi),
        .rev_level_high(rev_hi), .phase_out(phase_out),
        .phase_oe(phase_oe), .counter_three(cnt3));

    bgc_hall_model u_bgc_hall_model (.core_clk(core_clk), .nrst(nrst),
        .step(step), .hall_capture(hall));

    // 125 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // verdict and end of run
    task automatic test_done();
        if (err_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // one whole-word transfer; address held until hready, then data phase
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge core_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, rd2);
    endtask : wr

    // expected pin levels for on-vector, pwm selects and active levels
    function automatic logic [5:0] pins(input logic [5:0] on,
                                        input logic p, input logic n);
        logic [5:0] r;
        for (int i = 0; i < 6; i++) begin
            if (i < 3) r[i] = on[i] ? (p ? pwm[i] : pos_hi) : ~pos_hi;
            else r[i] = on[i] ? (n ? pwm[i] : rev_hi) : ~rev_hi;
        end
        return r;
    endfunction : pins

    localparam logic [5:0] ON_TBL [8] = '{
        6'h00, 6'h21, 6'h0a, 6'h22, 6'h14, 6'h11, 6'h0c, 6'h00
    };

    // program mode and gate register, let the pins settle, compare
    task automatic gate_case(input logic [7:0] g, input logic [1:0] m,
                             input logic [5:0] exp);
        wr(bgc_pkg::ADDR_CTL, {30'h0, m});
        wr(bgc_pkg::ADDR_GATE, {24'h0, g});
        repeat (2) @(posedge core_clk);
        check(32'(phase_out), 32'(exp));
    endtask : gate_case

    // reset values, read-only and unmapped places
    task automatic t_reset();
        xfer(1'b0, bgc_pkg::ADDR_GATE, 0, rd); check(rd, 32'h80);
        xfer(1'b0, bgc_pkg::ADDR_SUB, 0, rd); check(rd, 32'h0);
        xfer(1'b0, bgc_pkg::ADDR_DTO, 0, rd); check(rd, 32'hffff);
        xfer(1'b0, bgc_pkg::ADDR_OME, 0, rd); check(rd, 32'hc0);
        xfer(1'b0, 8'h20, 0, rd);
        check(rd, 32'h0);
        check(32'(phase_oe), 32'h0);
        check(32'(hresp), 32'h0);
    endtask : t_reset

    // software phase bits, every code, both pwm selects and levels
    task automatic t_soft();
        wr(bgc_pkg::ADDR_OME, 32'hff);
        repeat (2) @(posedge core_clk);
        check(32'(phase_oe), 32'h3f);
        for (int c = 0; c < 8; c++)
            gate_case(8'hc8 | c[7:0], 2'h1, pins(ON_TBL[c], 0, 0));
        for (int c = 1; c < 7; c++)
            gate_case(8'hf8 | c[7:0], 2'h2, pins(ON_TBL[c], 1, 1));
        gate_case(8'hd9, 2'h1, pins(ON_TBL[1], 1, 0));
        pos_hi <= 1'b0;
        rev_hi <= 1'b0;
        // let the new levels land before the expectation reads them
        @(posedge core_clk);
        gate_case(8'hcd, 2'h2, pins(ON_TBL[5], 0, 0));
        pos_hi <= 1'b1;
        rev_hi <= 1'b1;
    endtask : t_soft

    // hall feedback drives the gating; phase bits are ignored
    task automatic t_hall();
        for (int s = 0; s < 6; s++) begin
            step <= s[2:0];
            repeat (2) @(posedge core_clk);
            gate_case(8'hc7, 2'h1, pins(ON_TBL[hall], 0, 0));
        end
        step <= 3'h2;
        gate_case(8'hc8, 2'h1, pins(ON_TBL[0], 0, 0));
    endtask : t_hall

    // gating off: plain pwm passes through
    task automatic t_plain();
        gate_case(8'h89, 2'h1, pwm);
        gate_case(8'hc9, 2'h0, pwm);
        gate_case(8'hc9, 2'h3, pwm);
        wr(bgc_pkg::ADDR_OME, 32'hc0);
        repeat (2) @(posedge core_clk);
        check(32'(phase_oe), 32'h0);
    endtask : t_plain

    // restart loads the offset into counter three, subcounter is read-only
    task automatic t_count();
        wr(bgc_pkg::ADDR_DTO, 32'h1234);
        xfer(1'b0, bgc_pkg::ADDR_DTO, 0, rd); check(rd, 32'h1234);
        wr(bgc_pkg::ADDR_CTL, 32'h5);
        for (int i = 0; i < 8 && cnt3 !== 16'h1234; i++)
            @(posedge core_clk);
        check(32'(cnt3), 32'h1234);
        @(posedge core_clk);
        check(32'(cnt3), 32'h1235);
        // clock enable low freezes the running counter
        core_ce <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(32'(cnt3), 32'h1236);
        core_ce <= 1'b1;
        wr(bgc_pkg::ADDR_CTL, 32'h1);
        wr(bgc_pkg::ADDR_SUB, 32'hbeef);
        xfer(1'b0, bgc_pkg::ADDR_SUB, 0, rd);
        xfer(1'b0, bgc_pkg::ADDR_SUB, 0, rd2);
        check(rd2, rd);
        check(32'(rd == 32'hbeef), 32'h0);
    endtask : t_count

    // main sequence
    initial begin
        nrst = 1'b0;
        core_ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pwm = 6'h2d;
        pos_hi = 1'b1;
        rev_hi = 1'b1;
        step = 3'h0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_soft();
        t_hall();
        t_plain();
        t_count();
        test_done();
    end
endmodule : tb_bgc_top
